// ==== rtl/csp_pkg.sv ====
package csp_pkg;

   // ------------------------------------------------------------
   // Register map, byte offsets from the socket base
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFF_IF_STATUS   = 12'h0801;
   localparam logic [11:0] OFF_POWER_CTRL  = 12'h0802;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  POWER_CTRL_RST  = 8'h00;
   localparam logic [7:0]  READ_DATA_RST   = 8'h00;

   // ------------------------------------------------------------
   // Interface status field positions
   // ------------------------------------------------------------
   localparam int STS_RSVD_BIT    = 7;
   localparam int STS_POWER_BIT   = 6;
   localparam int STS_READY_BIT   = 5;
   localparam int STS_WP_BIT      = 4;
   localparam int STS_DETECT2_BIT = 3;
   localparam int STS_DETECT1_BIT = 2;
   localparam int STS_BVD2_BIT    = 1;
   localparam int STS_BVD1_BIT    = 0;

   // ------------------------------------------------------------
   // Power control field positions
   // ------------------------------------------------------------
   localparam int PWR_GATE_BIT    = 7;
   localparam int PWR_AUTO_BIT    = 5;
   localparam int PWR_VCCEN_BIT   = 4;
   localparam int PWR_VCC_HI      = 4;
   localparam int PWR_VCC_LO      = 3;
   localparam int PWR_VPP_HI      = 1;
   localparam int PWR_VPP_LO      = 0;

   // Writable bits of each layout; all others read zero
   localparam logic [7:0]  LEGACY_RW_MASK  = 8'h00b3;
   localparam logic [7:0]  NEWER_RW_MASK   = 8'h009b;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [3:0]  LEGACY_REVISION = 4'h0002;
   localparam logic [1:0]  VCC_REQ_5V      = 2'h2;
   localparam logic [1:0]  VCC_REQ_3V3     = 2'h3;
   localparam logic [1:0]  VPP_REQ_NONE    = 2'h0;

   typedef enum logic {CSP_LAYOUT_NEWER, CSP_LAYOUT_LEGACY} csp_layout_e;

endpackage

// ==== rtl/csp_socket_regs.sv ====
`timescale 1ns/1ps

// Operation
// RULE1: Status bit 7 always reads zero.
// RULE2: Status bit 6 shows socket power on, from power control programming.
// RULE3: Status bit 5 shows the card ready pin.
// RULE4: Status bit 4 shows the write-protect pin at same level.
// RULE5: Status bit 3 is the inverse of the second card-detect pin.
// RULE6: Status bit 2 is the inverse of the first card-detect pin.
// RULE7: Memory card: bit 1 battery detect two, bit 0 battery detect one.
// RULE8: I/O card: speaker and status-change pass undecoded into bits 1 and 0.
// RULE9: After reset upper status bits read zero, the rest are live.
// RULE10: Two power control layouts, chosen by the revision field.
// RULE11: Revision pattern 0010b selects the older layout.
// RULE12: Power bit 7 gates all card outputs, default off.
// RULE13: Older layout: power bit 6 reads zero.
// RULE14: Older layout: bit 5 enables automatic power switching by card detects.
// RULE15: Older layout: bit 4 enables Vcc at level from system control.
// RULE16: Older layout: power bits 3 and 2 read zero.
// RULE17: Bits 1:0 request Vpp, ignored while Vcc is disabled.
// RULE18: Newer layout: bits 4:3 request Vcc; bits 6, 5, 2 read zero.
// RULE19: Power control resets to zero; reserved bits read-only.
// RULE20: Whole-window write protect adds to the card write-protect pin.
// RULE21: Reads have no side effects; status writes are ignored.
module csp_socket_regs
   import csp_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rstn,
   // Host memory access at socket base
   input  wire logic [ADDR_W-1:0] hostAddr,
   input  wire logic              hostWrite,
   input  wire logic              hostRead,
   input  wire logic [7:0]        hostWriteData,
   output logic      [7:0]        hostReadData,
   output logic                   hostReadValid,
   // Settings held by neighbouring registers
   input  wire logic [3:0]        compatRevisionField,
   input  wire logic              vccLevelSelect,
   input  wire logic              windowWriteProtect,
   // Card pins, asynchronous
   input  wire logic              cardReady,
   input  wire logic              cardWriteProtect,
   input  wire logic              cardDetectOne_n,
   input  wire logic              cardDetectTwo_n,
   input  wire logic              cardBvd1Status,
   input  wire logic              cardBvd2Speaker,
   // Socket controls
   output logic                   cardOutputGate,
   output logic                   autoPowerSwitchOn,
   output logic                   socketPowerOnFlag,
   output logic                   vccLevelSelOut,
   output logic      [1:0]        vccRequestField,
   output logic      [1:0]        vppRequestField,
   output logic                   memWriteBlocked
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [5:0]  pinMeta_reg;
   logic [5:0]  pinSync_reg;
   logic [7:0]  powerCtrl_reg;
   logic [7:0]  powerCtrl_next;
   logic [7:0]  statusView;
   logic [7:0]  powerView;
   logic [7:0]  rwMask;
   csp_layout_e layout;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pinMeta_reg <= 6'h00;
         pinSync_reg <= 6'h00;
      end
      else
      begin
         pinMeta_reg <= {cardReady, cardWriteProtect, cardDetectTwo_n,
                         cardDetectOne_n, cardBvd2Speaker, cardBvd1Status};
         pinSync_reg <= pinMeta_reg;
      end
   end

   // ------------------------------------------------------------
   // Layout selection
   // ------------------------------------------------------------
   // RULE10: layout from revision
   // RULE11: 0010b picks older
   assign layout = (compatRevisionField == LEGACY_REVISION) ? CSP_LAYOUT_LEGACY
                                                            : CSP_LAYOUT_NEWER;
   // RULE16: reserved bits masked
   // RULE18: newer reserved masked
   assign rwMask = (layout == CSP_LAYOUT_LEGACY) ? LEGACY_RW_MASK : NEWER_RW_MASK;

   // ------------------------------------------------------------
   // Power control register
   // ------------------------------------------------------------
   always_comb
   begin
      powerCtrl_next = powerCtrl_reg;
      // RULE21: status writes ignored
      if (hostWrite && hostAddr == OFF_POWER_CTRL)
      begin
         powerCtrl_next = (powerCtrl_reg & ~rwMask) | (hostWriteData & rwMask);
      end
   end

   // RULE19: reset to zero
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         powerCtrl_reg <= POWER_CTRL_RST;
      end
      else
      begin
         powerCtrl_reg <= powerCtrl_next;
      end
   end

   // Bits kept from the other layout stay hidden until it returns
   // RULE13: bit 6 reads zero
   assign powerView = powerCtrl_reg & rwMask;

   // ------------------------------------------------------------
   // Socket controls
   // ------------------------------------------------------------
   // RULE12: output gate
   assign cardOutputGate    = powerCtrl_reg[PWR_GATE_BIT];
   // RULE14: auto switching enable
   assign autoPowerSwitchOn = (layout == CSP_LAYOUT_LEGACY) && powerCtrl_reg[PWR_AUTO_BIT];

   always_comb
   begin
      vccRequestField = VPP_REQ_NONE;
      vccLevelSelOut  = 1'b0;
      if (layout == CSP_LAYOUT_LEGACY)
      begin
         // RULE15: level from system control
         if (powerCtrl_reg[PWR_VCCEN_BIT])
         begin
            vccRequestField = vccLevelSelect ? VCC_REQ_3V3 : VCC_REQ_5V;
            vccLevelSelOut  = vccLevelSelect;
         end
      end
      else
      begin
         // RULE18: 00 and 01 mean 0 V
         if (powerCtrl_reg[PWR_VCC_HI])
         begin
            vccRequestField = powerCtrl_reg[PWR_VCC_HI:PWR_VCC_LO];
            vccLevelSelOut  = powerCtrl_reg[PWR_VCC_LO];
         end
      end
   end

   // RULE2: power follows programming
   assign socketPowerOnFlag = vccRequestField[1];
   // RULE17: Vpp needs Vcc
   assign vppRequestField   = socketPowerOnFlag ? powerCtrl_reg[PWR_VPP_HI:PWR_VPP_LO]
                                                : VPP_REQ_NONE;
   // RULE20: window write protect
   assign memWriteBlocked   = pinSync_reg[4] | windowWriteProtect;

   // ------------------------------------------------------------
   // Interface status view
   // ------------------------------------------------------------
   always_comb
   begin
      statusView                  = 8'h00;
      // RULE1: bit 7 zero
      statusView[STS_RSVD_BIT]    = 1'b0;
      statusView[STS_POWER_BIT]   = socketPowerOnFlag;
      // RULE3: ready pin
      statusView[STS_READY_BIT]   = pinSync_reg[5];
      // RULE4: write protect pin
      statusView[STS_WP_BIT]      = pinSync_reg[4];
      // RULE5: inverted detect two
      statusView[STS_DETECT2_BIT] = ~pinSync_reg[3];
      // RULE6: inverted detect one
      statusView[STS_DETECT1_BIT] = ~pinSync_reg[2];
      // RULE7: battery detect pins
      // RULE8: shared pins undecoded
      statusView[STS_BVD2_BIT]    = pinSync_reg[1];
      statusView[STS_BVD1_BIT]    = pinSync_reg[0];
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   // RULE21: reads change nothing
   // RULE9: upper bits zero from reset
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hostReadData  <= READ_DATA_RST;
         hostReadValid <= 1'b0;
      end
      else
      begin
         hostReadValid <= hostRead;
         if (hostRead)
         begin
            case (hostAddr)
               OFF_IF_STATUS:  hostReadData <= statusView;
               OFF_POWER_CTRL: hostReadData <= powerView;
               default:        hostReadData <= READ_DATA_RST;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cspCb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   AST_STATUS_MSB_ZERO: assert property ( // RULE1
      hostRead && hostAddr == OFF_IF_STATUS |=> hostReadValid && !hostReadData[7])
      else $error("Status bit 7 read as one");

   AST_POWER_FLAG_READ: assert property ( // RULE2
      hostRead && hostAddr == OFF_IF_STATUS |=> hostReadData[6] == $past(socketPowerOnFlag))
      else $error("Status power bit does not match programming");

   AST_PIN_LEVELS: assert property ( // RULE3
      hostRead && hostAddr == OFF_IF_STATUS
      |=> hostReadData[5:4] == $past(pinSync_reg[5:4]))
      else $error("Ready or write-protect bit wrong");

   AST_DETECT_INVERTED: assert property ( // RULE5
      hostRead && hostAddr == OFF_IF_STATUS
      |=> hostReadData[3:2] == ~$past(pinSync_reg[3:2]))
      else $error("Card detect bits not inverted");

   AST_BATTERY_BITS: assert property ( // RULE7
      hostRead && hostAddr == OFF_IF_STATUS
      |=> hostReadData[1:0] == $past(pinSync_reg[1:0]))
      else $error("Battery detect bits wrong");

   AST_GATE_WRITE: assert property ( // RULE12
      hostWrite && hostAddr == OFF_POWER_CTRL ##1 !(hostWrite && hostAddr == OFF_POWER_CTRL)
      |-> cardOutputGate == $past(hostWriteData[7]))
      else $error("Output gate did not take written value");

   AST_LEGACY_RSVD_ZERO: assert property ( // RULE16
      hostRead && hostAddr == OFF_POWER_CTRL && layout == CSP_LAYOUT_LEGACY
      |=> hostReadData[6] == 1'b0 && hostReadData[3:2] == 2'h0)
      else $error("Older layout reserved bits nonzero");

   AST_NEWER_RSVD_ZERO: assert property ( // RULE18
      hostRead && hostAddr == OFF_POWER_CTRL && layout == CSP_LAYOUT_NEWER
      |=> hostReadData[6:5] == 2'h0 && hostReadData[2] == 1'b0)
      else $error("Newer layout reserved bits nonzero");

   AST_VPP_NEEDS_VCC: assert property ( // RULE17
      !socketPowerOnFlag |-> vppRequestField == VPP_REQ_NONE)
      else $error("Vpp requested with Vcc off");

   AST_STATUS_WRITE_IGNORED: assert property ( // RULE21
      hostWrite && hostAddr == OFF_IF_STATUS |=> $stable(powerCtrl_reg))
      else $error("Status write changed state");

   AST_READ_VALID_PULSE: assert property ( // RULE21
      hostRead
      |=> hostReadValid)
      else $error("Read not answered next cycle");

   AST_NO_SPURIOUS_VALID: assert property ( // RULE21
      !hostRead
      |=> !hostReadValid)
      else $error("Read valid without a read");

   AST_READ_DATA_HOLDS: assert property ( // RULE21
      !hostRead
      |=> $stable(hostReadData))
      else $error("Read data changed without a read");

   AST_UNMAPPED_READ_ZERO: assert property ( // RULE21
      hostRead && hostAddr != OFF_IF_STATUS && hostAddr != OFF_POWER_CTRL
      |=> hostReadData == READ_DATA_RST)
      else $error("Unmapped read returned nonzero");

   AST_LAYOUT_LEGACY: assert property ( // RULE11
      compatRevisionField == LEGACY_REVISION
      |-> layout == CSP_LAYOUT_LEGACY)
      else $error("Older layout not selected");

   AST_LAYOUT_NEWER: assert property ( // RULE10
      compatRevisionField != LEGACY_REVISION
      |-> layout == CSP_LAYOUT_NEWER)
      else $error("Newer layout not selected");

   AST_WRITE_LANDS: assert property ( // RULE19
      hostWrite && hostAddr == OFF_POWER_CTRL
      |=> (powerCtrl_reg & $past(rwMask)) == ($past(hostWriteData) & $past(rwMask)))
      else $error("Writable power bits did not take written value");

   AST_RSVD_HELD: assert property ( // RULE19
      hostWrite && hostAddr == OFF_POWER_CTRL
      |=> (powerCtrl_reg & ~$past(rwMask)) == ($past(powerCtrl_reg) & ~$past(rwMask)))
      else $error("Reserved power bits changed by a write");

   AST_POWER_READ_MASKED: assert property ( // RULE16
      hostRead && hostAddr == OFF_POWER_CTRL
      |=> (hostReadData & ~$past(rwMask)) == 8'h00)
      else $error("Reserved power bits read nonzero");

   AST_LEGACY_BIT6_ZERO: assert property ( // RULE13
      layout == CSP_LAYOUT_LEGACY
      |-> !powerView[6])
      else $error("Older layout bit 6 visible");

   AST_AUTO_LEGACY_ONLY: assert property ( // RULE14
      layout == CSP_LAYOUT_NEWER
      |-> !autoPowerSwitchOn)
      else $error("Auto switching on in newer layout");

   AST_LEGACY_VCC_OFF: assert property ( // RULE15
      layout == CSP_LAYOUT_LEGACY && !powerCtrl_reg[PWR_VCCEN_BIT]
      |-> vccRequestField == 2'h0)
      else $error("Older layout Vcc on without enable");

   AST_LEGACY_VCC_LEVEL: assert property ( // RULE15
      layout == CSP_LAYOUT_LEGACY && powerCtrl_reg[PWR_VCCEN_BIT]
      |-> vccRequestField == {1'b1, vccLevelSelect})
      else $error("Older layout Vcc level wrong");

   AST_NEWER_VCC_OFF: assert property ( // RULE18
      layout == CSP_LAYOUT_NEWER && !powerCtrl_reg[PWR_VCC_HI]
      |-> vccRequestField == 2'h0)
      else $error("Newer layout Vcc on for a zero volt code");

   AST_VPP_FOLLOWS: assert property ( // RULE17
      socketPowerOnFlag
      |-> vppRequestField == powerCtrl_reg[PWR_VPP_HI:PWR_VPP_LO])
      else $error("Vpp request not passed while Vcc on");

   AST_WINDOW_PROTECT: assert property ( // RULE20
      windowWriteProtect
      |-> memWriteBlocked)
      else $error("Window write protect not applied");

endmodule

// ==== tb/csp_card_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Card at the socket pins
// ------------------------------------------------------------
module csp_card_model
(
   // Card state chosen by the bench
   input  wire logic       present,
   input  wire logic       ready,
   input  wire logic       wp,
   input  wire logic [1:0] bvd,
   // Socket pins
   output logic            cardReady,
   output logic            cardWriteProtect,
   output logic            cardDetectOne_n,
   output logic            cardDetectTwo_n,
   output logic            cardBvd1Status,
   output logic            cardBvd2Speaker
);
   // Empty socket: detects pulled up, other pins pulled down
   assign cardDetectOne_n  = ~present;
   assign cardDetectTwo_n  = ~present;
   assign cardReady        = ready & present;
   assign cardWriteProtect = wp & present;
   assign cardBvd1Status   = bvd[0] & present;
   assign cardBvd2Speaker  = bvd[1] & present;
endmodule

// ==== tb/card_socket_status_power_regs_tb.sv ====
`timescale 1ns/1ps

module card_socket_status_power_regs_tb
   import csp_pkg::*;
;
   typedef struct packed {
      logic [3:0] rev;
      logic       lvl;
      logic [7:0] wd;
      logic [7:0] rdv;
      logic [1:0] vcc;
      logic [1:0] vpp;
      logic       gate;
      logic       auto;
   } csp_row_s;

   logic              core_clk, rstn, hostWrite, hostRead, hostReadValid;
   logic [ADDR_W-1:0] hostAddr;
   logic [7:0]        hostWriteData, hostReadData, d;
   logic [3:0]        compatRevisionField;
   logic              vccLevelSelect, windowWriteProtect, cPresent, cReady, cWp;
   logic [1:0]        cBvd, vccRequestField, vppRequestField;
   logic              pRdy, pWp, pCd1, pCd2, pB1, pB2, cardOutputGate;
   logic              autoPowerSwitchOn, socketPowerOnFlag, vccLevelSelOut, memWriteBlocked;
   int                nMismatch, checksDone;
   // Bit 2 is never writable, so row 4 also proves 01 means no Vcc
   csp_row_s          rows [6] = '{
      '{4'h2, 1'b0, 8'hFF, 8'hB3, 2'h2, 2'h3, 1'b1, 1'b1},
      '{4'h2, 1'b0, 8'h23, 8'h23, 2'h0, 2'h0, 1'b0, 1'b1},
      '{4'h2, 1'b1, 8'h92, 8'h92, 2'h3, 2'h2, 1'b1, 1'b0},
      '{4'h0, 1'b0, 8'hFF, 8'h9B, 2'h3, 2'h3, 1'b1, 1'b0},
      '{4'h0, 1'b1, 8'h0E, 8'h0A, 2'h0, 2'h0, 1'b0, 1'b0},
      '{4'hF, 1'b0, 8'h11, 8'h11, 2'h2, 2'h1, 1'b0, 1'b0}};
   logic [4:0]        pats [4] = '{5'h00, 5'h1F, 5'h15, 5'h1A};

   csp_socket_regs dut (.core_clk(core_clk), .rstn(rstn), .hostAddr(hostAddr),
      .hostWrite(hostWrite), .hostRead(hostRead), .hostWriteData(hostWriteData),
      .hostReadData(hostReadData), .hostReadValid(hostReadValid),
      .compatRevisionField(compatRevisionField), .vccLevelSelect(vccLevelSelect),
      .windowWriteProtect(windowWriteProtect), .cardReady(pRdy), .cardWriteProtect(pWp),
      .cardDetectOne_n(pCd1), .cardDetectTwo_n(pCd2), .cardBvd1Status(pB1),
      .cardBvd2Speaker(pB2), .cardOutputGate(cardOutputGate),
      .autoPowerSwitchOn(autoPowerSwitchOn), .socketPowerOnFlag(socketPowerOnFlag),
      .vccLevelSelOut(vccLevelSelOut), .vccRequestField(vccRequestField),
      .vppRequestField(vppRequestField), .memWriteBlocked(memWriteBlocked));

   csp_card_model card (.present(cPresent), .ready(cReady), .wp(cWp), .bvd(cBvd),
      .cardReady(pRdy), .cardWriteProtect(pWp), .cardDetectOne_n(pCd1),
      .cardDetectTwo_n(pCd2), .cardBvd1Status(pB1), .cardBvd2Speaker(pB2));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] stsExp(input logic on);
      return {1'b0, on, cReady & cPresent, cWp & cPresent, cPresent, cPresent,
              cBvd & {2{cPresent}}};
   endfunction

   task automatic finishTest();
      $display("Checks %0d, mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge core_clk);
      #1 hostWrite = 1'b1;
      hostAddr = a;
      hostWriteData = v;
      @(posedge core_clk);
      #1 hostWrite = 1'b0;
   endtask

   // Valid is registered on the taking edge itself; four more edges is the bound
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge core_clk);
      #1 hostRead = 1'b1;
      hostAddr = a;
      @(posedge core_clk);
      #1 hostRead = 1'b0;
      for (int n = 0; n < 4 && hostReadValid !== 1'b1; n++)
         @(posedge core_clk) #1;
      if (hostReadValid !== 1'b1)
      begin
         nMismatch++;
         $display("Error %0t: read not answered", $time);
         finishTest();
      end
      else
         v = hostReadData;
   endtask

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial
   begin
      {rstn, hostWrite, hostRead, vccLevelSelect, windowWriteProtect} = '0;
      {cPresent, cReady, cWp, cBvd, hostAddr, hostWriteData, compatRevisionField} = '0;
      repeat (12) @(posedge core_clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge core_clk);
      rd(OFF_POWER_CTRL, d);
      chk(d, POWER_CTRL_RST);
      chk({7'h0, cardOutputGate}, 8'h00);
      rd(OFF_IF_STATUS, d);
      chk(d, stsExp(1'b0));
      foreach (rows[i])
      begin
         compatRevisionField = rows[i].rev;
         vccLevelSelect = rows[i].lvl;
         wr(OFF_POWER_CTRL, rows[i].wd);
         rd(OFF_POWER_CTRL, d);
         chk(d, rows[i].rdv);
         chk({2'b0, cardOutputGate, autoPowerSwitchOn, vccRequestField, vppRequestField},
             {2'b0, rows[i].gate, rows[i].auto, rows[i].vcc, rows[i].vpp});
         chk({6'h0, socketPowerOnFlag, vccLevelSelOut},
             {6'h0, rows[i].vcc != 2'h0, rows[i].vcc == 2'h3});
         rd(OFF_IF_STATUS, d);
         chk(d, stsExp(rows[i].vcc != 2'h0));
      end
      for (int i = 0; i < 4; i++)
      begin
         {cPresent, cReady, cWp, cBvd} = pats[i];
         windowWriteProtect = i[0];
         repeat (3) @(posedge core_clk);
         rd(OFF_IF_STATUS, d);
         chk(d, stsExp(1'b1));
         chk({7'h0, memWriteBlocked}, {7'h0, (cWp & cPresent) | windowWriteProtect});
      end
      wr(OFF_IF_STATUS, 8'hFF);
      wr(12'h803, 8'hFF);
      rd(OFF_POWER_CTRL, d);
      chk(d, 8'h11);
      rd(12'h803, d);
      chk(d, 8'h00);
      rd(OFF_IF_STATUS, d);
      chk(d, stsExp(1'b1));
      // Read and write together: the read sees the old value
      @(posedge core_clk);
      #1 {hostRead, hostWrite} = 2'b11;
      hostAddr = OFF_POWER_CTRL;
      hostWriteData = 8'h80;
      @(posedge core_clk);
      #1 {hostRead, hostWrite} = 2'b00;
      chk(hostReadData, 8'h11);
      rd(OFF_POWER_CTRL, d);
      chk({d[7:1], cardOutputGate}, 8'h81);
      rstn = 1'b0;
      @(posedge core_clk);
      #1 rstn = 1'b1;
      rd(OFF_POWER_CTRL, d);
      chk({d[7:1], cardOutputGate}, 8'h00);
      finishTest();
   end
endmodule
